// >>> include/scc_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_CRC_POLY        8'h31
`define SCC_CRC_INIT        8'h00
`define SCC_CHECK_BITS      8'd8
`define SCC_DATA_BYTES      2'd3
`define SCC_FRAME_BITS      8'd32
`define SCC_ERR_CRC         0
`define SCC_ERR_ADDR        1
`define SCC_ERR_TEMP        2
`define SCC_START_RST       7'h00
`define SCC_STOP_RST        7'h7f
`define SCC_CTRL2_RST       8'h00
`define SCC_THERM_110       8'd110
`define SCC_THERM_130       8'd130
`define SCC_THERM_150       8'd150
`define SCC_THERM_OFF       2'b11
`define SCC_PIN_SYNC_RST    8'hc0
`define SCC_CLK_NS          10
`define SCC_SCLK_HALF_NS    60
`define SCC_SCLK_HALF_CYC   ((`SCC_SCLK_HALF_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_OFF_DATA        12'h000
`define SCC_OFF_CTRL        12'h004
`define SCC_OFF_STATUS      12'h008
`define SCC_OFF_READBACK    12'h00c
`define SCC_CTRL_GO         0
`define SCC_CTRL_CORRUPT    1
`define SCC_CTRL_CHIP_OFF   2
`define SCC_CTRL_RX_OFF     3
`define SCC_CTRL_STYLE      4
`define SCC_CTRL_RST        5'h0c
`endif

// >>> include/scc_pkg.sv
// shared types and check-value arithmetic
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_LEAD,
    SCC_HIGH,
    SCC_LOW,
    SCC_TRAIL
  } scc_host_state_type;

  function automatic logic [7:0] scc_crc_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = crc[7] ^ bit_in;
    return {crc[6:0], 1'b0} ^ (fb ? 8'h31 : 8'h00);
  endfunction : scc_crc_step

  function automatic logic [7:0] scc_crc_word(input logic [23:0] data);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      crc = scc_crc_step(crc, data[i]);
    end
    return crc;
  endfunction : scc_crc_word
endpackage : scc_pkg

// >>> include/scc_link_if.sv
// serial configuration link between host controller and device
`timescale 1ns/1ps
interface scc_link_if;
  logic serial_clock_pos;
  logic select_pos;
  logic serial_in_line;
  logic serial_out_line;
  logic fault_out;
  logic fault_oe;
  wire  fault_line;

  // open-drain fault pin with external pull-up
  assign fault_line = fault_oe ? fault_out : 1'b1;

  modport host_mp (
    output serial_clock_pos,
    output select_pos,
    output serial_in_line,
    input  serial_out_line,
    input  fault_line
  );

  modport device_mp (
    input  serial_clock_pos,
    input  select_pos,
    input  serial_in_line,
    output serial_out_line,
    output fault_out,
    output fault_oe
  );
endinterface : scc_link_if

// >>> logic/scc_device.sv
// device end: serial check-value receiver and sticky fault flags
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_device (
  input  wire logic        pclk,
  input  wire logic        presetn,
  scc_link_if.device_mp    lnk,
  input  wire logic        chip_disable,
  input  wire logic        serial_receiver_off_request,
  input  wire logic        clock_input_style_select,
  input  wire logic        main_clock_pos,
  input  wire logic        main_clock_neg,
  input  wire logic [7:0]  junction_temp,
  output logic      [7:0]  fault_flags,
  output logic      [7:0]  received_check_value,
  output logic      [7:0]  computed_check_value,
  output logic      [6:0]  start_addr,
  output logic      [6:0]  stop_addr,
  output logic      [1:0]  thermal_limit_select,
  output logic             main_clock_level
);
  // pin order: chip_off, rx_off, style, main_clock_pos, main_clock_neg, sclk, select, data
  logic [7:0]  pin_s1_r;
  logic [7:0]  pin_s2_r;
  logic [7:0]  temp_s1_r;
  logic [7:0]  temp_s2_r;
  logic [2:0]  edge_s3_r;
  logic        chip_off;
  logic        rx_off;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sel_rise;
  logic        sel_fall;
  logic        chip_on_edge;
  logic        frame_r;
  logic [7:0]  nbits_r;
  logic [7:0]  win_r;
  logic [7:0]  crc_r;
  logic [7:0]  data_sr_r;
  logic [6:0]  shadow_start_r;
  logic [6:0]  shadow_stop_r;
  logic [7:0]  shadow_ctrl_r;
  logic [23:0] tx_sr_r;
  logic [7:0]  data_idx;
  logic        frame_end;
  logic        check_ok;
  logic [7:0]  thresh;
  logic [2:0]  err_set;
  logic [7:0]  flags_nxt;
  logic        fault_oe_r;
  logic        sout_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r  <= `SCC_PIN_SYNC_RST;
      pin_s2_r  <= `SCC_PIN_SYNC_RST;
      temp_s1_r <= 8'h00;
      temp_s2_r <= 8'h00;
      edge_s3_r <= 3'h4;
    end else begin
      pin_s1_r  <= {chip_disable, serial_receiver_off_request, clock_input_style_select,
                    main_clock_pos, main_clock_neg, lnk.serial_clock_pos,
                    lnk.select_pos, lnk.serial_in_line};
      pin_s2_r  <= pin_s1_r;
      temp_s1_r <= junction_temp;
      temp_s2_r <= temp_s1_r;
      edge_s3_r <= {pin_s2_r[7], pin_s2_r[2], pin_s2_r[1]};
    end
  end

  assign chip_off     = pin_s2_r[7];
  assign rx_off       = pin_s2_r[6];
  assign sclk_rise    = pin_s2_r[2] & ~edge_s3_r[1];
  assign sclk_fall    = ~pin_s2_r[2] & edge_s3_r[1];
  assign sel_rise     = pin_s2_r[1] & ~edge_s3_r[0];
  assign sel_fall     = ~pin_s2_r[1] & edge_s3_r[0];
  assign chip_on_edge = edge_s3_r[2] & ~chip_off;
  assign data_idx     = nbits_r - `SCC_CHECK_BITS;
  assign frame_end    = frame_r & sel_fall;
  assign check_ok     = (win_r == crc_r);

  // frame runs only while chip and receiver are enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= 1'b0;
    end else if (chip_off || rx_off) begin
      frame_r <= 1'b0;
    end else if (sel_rise) begin
      frame_r <= 1'b1;
    end else if (sel_fall) begin
      frame_r <= 1'b0;
    end
  end

  // last 8 bits stay in the window; older bits feed the check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbits_r   <= 8'h00;
      win_r     <= 8'h00;
      crc_r     <= `SCC_CRC_INIT;
      data_sr_r <= 8'h00;
    end else if (sel_rise && !chip_off && !rx_off) begin
      nbits_r   <= 8'h00;
      win_r     <= 8'h00;
      crc_r     <= `SCC_CRC_INIT;
      data_sr_r <= 8'h00;
    end else if (frame_r && sclk_rise) begin
      win_r <= {win_r[6:0], pin_s2_r[0]};
      if (nbits_r != 8'hff) begin
        nbits_r <= nbits_r + 8'h01;
      end
      if (nbits_r >= `SCC_CHECK_BITS) begin
        crc_r     <= scc_pkg::scc_crc_step(crc_r, win_r[7]);
        data_sr_r <= {data_sr_r[6:0], win_r[7]};
      end
    end
  end

  // data bytes wait in shadows until the frame checks good
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_start_r <= `SCC_START_RST;
      shadow_stop_r  <= `SCC_STOP_RST;
      shadow_ctrl_r  <= `SCC_CTRL2_RST;
    end else if (frame_r && sclk_rise && nbits_r >= `SCC_CHECK_BITS
                 && data_idx[2:0] == 3'h7) begin
      if (data_idx[7:3] == 5'd0) begin
        shadow_start_r <= {data_sr_r[5:0], win_r[7]};
      end else if (data_idx[7:3] == 5'd1) begin
        shadow_stop_r <= {data_sr_r[5:0], win_r[7]};
      end else if (data_idx[7:3] == 5'd2) begin
        shadow_ctrl_r <= {data_sr_r[6:0], win_r[7]};
      end
    end
  end

  // a frame shorter than the check byte is dropped without compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      received_check_value <= 8'h00;
      computed_check_value <= 8'h00;
      start_addr           <= `SCC_START_RST;
      stop_addr            <= `SCC_STOP_RST;
      thermal_limit_select <= 2'(`SCC_CTRL2_RST);
    end else if (frame_end && nbits_r >= `SCC_CHECK_BITS) begin
      received_check_value <= win_r;
      computed_check_value <= crc_r;
      if (check_ok && nbits_r == `SCC_FRAME_BITS) begin
        start_addr           <= shadow_start_r;
        stop_addr            <= shadow_stop_r;
        thermal_limit_select <= shadow_ctrl_r[1:0];
      end
    end
  end

  always_comb begin
    case (thermal_limit_select)
      2'b00:   thresh = `SCC_THERM_110;
      2'b01:   thresh = `SCC_THERM_130;
      default: thresh = `SCC_THERM_150;
    endcase
  end

  // set wins over the enable-edge clear
  always_comb begin
    err_set = 3'h0;
    err_set[`SCC_ERR_CRC]  = frame_end && nbits_r >= `SCC_CHECK_BITS && !check_ok;
    err_set[`SCC_ERR_ADDR] = (start_addr == stop_addr);
    err_set[`SCC_ERR_TEMP] = (thermal_limit_select != `SCC_THERM_OFF)
                             && (temp_s2_r > thresh);
    flags_nxt = (chip_on_edge ? 8'h00 : fault_flags) | {5'h00, err_set};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flags <= 8'h00;
      fault_oe_r  <= 1'b0;
    end else begin
      fault_flags <= flags_nxt;
      fault_oe_r  <= |flags_nxt[2:0];
    end
  end

  // readback of the previous results, shifted out on falling edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sr_r <= 24'h000000;
      sout_r  <= 1'b0;
    end else if (sel_rise && !chip_off && !rx_off) begin
      tx_sr_r <= {fault_flags[6:0], computed_check_value, received_check_value, 1'b0};
      sout_r  <= fault_flags[7];
    end else if (frame_r && sclk_fall) begin
      tx_sr_r <= {tx_sr_r[22:0], 1'b0};
      sout_r  <= tx_sr_r[23];
    end
  end

  // single-ended takes the positive pin; differential needs both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_clock_level <= 1'b0;
    end else if (pin_s2_r[5]) begin
      main_clock_level <= pin_s2_r[4];
    end else begin
      main_clock_level <= pin_s2_r[4] & ~pin_s2_r[3];
    end
  end

  assign lnk.serial_out_line = sout_r;
  assign lnk.fault_out       = 1'b0;
  assign lnk.fault_oe        = fault_oe_r;
endmodule : scc_device

// >>> logic/scc_host.sv
// host end: apb-controlled serial frame sender with check byte
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_host #(
  parameter int HALF_CYC = `SCC_SCLK_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  scc_link_if.host_mp      lnk,
  output logic             chip_disable_out,
  output logic             receiver_off_out,
  output logic             clock_style_out
);
  scc_pkg::scc_host_state_type state_r;
  logic [23:0] data_r;
  logic        corrupt_r;
  logic [31:0] shift_r;
  logic [31:0] rd_sr_r;
  logic [23:0] readback_r;
  logic [7:0]  bits_r;
  logic [15:0] cnt_r;
  logic        sclk_r;
  logic        sel_r;
  logic        sdo_r;
  logic [1:0]  sin_sync_r;
  logic [1:0]  fault_sync_r;
  logic        wr_en;
  logic        go;
  logic        half_done;

  assign wr_en     = psel && penable && pready && pwrite;
  assign go        = wr_en && paddr == `SCC_OFF_CTRL && pwdata[`SCC_CTRL_GO]
                     && state_r == scc_pkg::SCC_IDLE;
  assign half_done = (cnt_r == 16'h0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_sync_r   <= 2'b00;
      fault_sync_r <= 2'b11;
    end else begin
      sin_sync_r   <= {sin_sync_r[0], lnk.serial_out_line};
      fault_sync_r <= {fault_sync_r[0], lnk.fault_line};
    end
  end

  // zero-wait apb slave: ready is registered from every setup cycle, so it is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == `SCC_OFF_DATA) begin
          prdata <= {8'h00, data_r};
        end else if (paddr == `SCC_OFF_CTRL) begin
          prdata <= {27'h0, clock_style_out, receiver_off_out, chip_disable_out,
                     corrupt_r, 1'b0};
        end else if (paddr == `SCC_OFF_STATUS) begin
          prdata <= {30'h0, ~fault_sync_r[1], state_r != scc_pkg::SCC_IDLE};
        end else if (paddr == `SCC_OFF_READBACK) begin
          prdata <= {8'h00, readback_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r           <= 24'h000000;
      corrupt_r        <= 1'b0;
      chip_disable_out <= 1'b1;
      receiver_off_out <= 1'b1;
      clock_style_out  <= 1'b0;
    end else if (wr_en && paddr == `SCC_OFF_DATA) begin
      data_r <= pwdata[23:0];
    end else if (wr_en && paddr == `SCC_OFF_CTRL) begin
      corrupt_r        <= pwdata[`SCC_CTRL_CORRUPT];
      chip_disable_out <= pwdata[`SCC_CTRL_CHIP_OFF];
      receiver_off_out <= pwdata[`SCC_CTRL_RX_OFF];
      clock_style_out  <= pwdata[`SCC_CTRL_STYLE];
    end
  end

  // half period of 6 cycles keeps the serial clock near 8 MHz, far below 100 MHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= scc_pkg::SCC_IDLE;
      cnt_r      <= 16'h0000;
      bits_r     <= 8'h00;
      shift_r    <= 32'h00000000;
      rd_sr_r    <= 32'h00000000;
      readback_r <= 24'h000000;
      sclk_r     <= 1'b0;
      sel_r      <= 1'b0;
      sdo_r      <= 1'b0;
    end else begin
      if (!half_done) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      case (state_r)
        scc_pkg::SCC_IDLE: begin
          if (go) begin
            shift_r <= {data_r[22:0], scc_pkg::scc_crc_word(data_r)
                        ^ {7'h00, pwdata[`SCC_CTRL_CORRUPT]}, 1'b0};
            sdo_r   <= data_r[23];
            sel_r   <= 1'b1;
            bits_r  <= 8'h00;
            cnt_r   <= 16'(HALF_CYC - 1);
            state_r <= scc_pkg::SCC_LEAD;
          end
        end
        scc_pkg::SCC_LEAD, scc_pkg::SCC_LOW: begin
          if (half_done) begin
            sclk_r  <= 1'b1;
            bits_r  <= bits_r + 8'h01;
            cnt_r   <= 16'(HALF_CYC - 1);
            state_r <= scc_pkg::SCC_HIGH;
          end
        end
        scc_pkg::SCC_HIGH: begin
          if (half_done) begin
            sclk_r  <= 1'b0;
            rd_sr_r <= {rd_sr_r[30:0], sin_sync_r[1]};
            cnt_r   <= 16'(HALF_CYC - 1);
            if (bits_r == `SCC_FRAME_BITS) begin
              state_r <= scc_pkg::SCC_TRAIL;
            end else begin
              sdo_r   <= shift_r[31];
              shift_r <= {shift_r[30:0], 1'b0};
              state_r <= scc_pkg::SCC_LOW;
            end
          end
        end
        scc_pkg::SCC_TRAIL: begin
          if (half_done) begin
            sel_r      <= 1'b0;
            readback_r <= rd_sr_r[31:8];
            state_r    <= scc_pkg::SCC_IDLE;
          end
        end
        default: state_r <= scc_pkg::SCC_IDLE;
      endcase
    end
  end

  assign lnk.serial_clock_pos = sclk_r;
  assign lnk.select_pos       = sel_r;
  assign lnk.serial_in_line   = sdo_r;
endmodule : scc_host

// >>> verification/scc_link_checker.sv
// assertions on the serial link between host and device ends
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_link_checker #(
  parameter int HALF_CYC = `SCC_SCLK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_clock_pos,
  input wire logic select_pos,
  input wire logic serial_in_line,
  input wire logic fault_out,
  input wire logic fault_oe,
  input wire logic chip_disable,
  input wire logic serial_receiver_off_request
);
  logic       sclk_d_r;
  logic [5:0] bits_r;
  logic [7:0] crc_r;
  logic [7:0] tail_r;
  logic [7:0] hi_r;
  logic       fb;

  assign fb = crc_r[7] ^ serial_in_line;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      hi_r <= 8'h00;
    end else begin
      sclk_d_r <= serial_clock_pos;
      hi_r <= serial_clock_pos ? hi_r + 8'h01 : 8'h00;
    end
  end

  // own check sum of the first 24 bits, zero start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_r <= 6'h00;
      crc_r <= 8'h00;
      tail_r <= 8'h00;
    end else if (!select_pos) begin
      bits_r <= 6'h00;
      crc_r <= 8'h00;
    end else if (serial_clock_pos && !sclk_d_r) begin
      bits_r <= bits_r + 6'h01;
      tail_r <= {tail_r[6:0], serial_in_line};
      if (bits_r < 6'h18) begin
        crc_r <= {crc_r[6:0], 1'b0} ^ (fb ? 8'h31 : 8'h00);
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lead;
    !serial_clock_pos [*2];
  endsequence
  sequence s_fault_soon;
    ##[1:6] fault_oe;
  endsequence

  property p_lead;
    $rose(select_pos) |-> s_lead;
  endproperty
  property p_idle;
    !select_pos |-> !serial_clock_pos;
  endproperty
  property p_high_len;
    $fell(serial_clock_pos) |-> hi_r == HALF_CYC;
  endproperty
  property p_hold;
    serial_clock_pos && sclk_d_r |-> $stable(serial_in_line);
  endproperty
  property p_sdo;
    $changed(serial_in_line) |-> !serial_clock_pos;
  endproperty
  property p_len;
    $fell(select_pos) && bits_r != 6'h00 |-> bits_r == 6'h20;
  endproperty
  // refused frames leave the flags alone, so only live ones count
  property p_bad;
    $fell(select_pos) && bits_r == 6'h20 && tail_r != crc_r && !chip_disable
      && !serial_receiver_off_request |-> s_fault_soon;
  endproperty
  property p_pull;
    fault_oe |-> !fault_out;
  endproperty

  a_lead: assert property (p_lead) else $error("clock began with select");
  a_idle: assert property (p_idle) else $error("clock outside frame");
  a_high_len: assert property (p_high_len) else $error("clock high length");
  a_hold: assert property (p_hold) else $error("data moved in high half");
  a_sdo: assert property (p_sdo) else $error("data moved with clock high");
  a_len: assert property (p_len) else $error("frame not 32 bits");
  a_bad: assert property (p_bad) else $error("mismatch without fault");
  a_pull: assert property (p_pull) else $error("fault pin driven high");
endmodule : scc_link_checker

// >>> verification/scc_tb_top.sv
// testbench: apb-driven host frames into device, flags checked
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_tb_top;
  typedef struct packed {
    logic [23:0] d;
    logic        c;
    logic [7:0]  t;
    logic [7:0]  f;
  } scc_row_type;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        cd;
  logic        ro;
  logic        cs;
  logic        mcp = 1'b0;
  logic        mcn = 1'b0;
  logic        mcl;
  logic [7:0]  temp = 8'h00;
  logic [7:0]  flags;
  logic [7:0]  rcv;
  logic [7:0]  cmp;
  logic [7:0]  c8;
  logic [6:0]  st;
  logic [6:0]  sp;
  logic [1:0]  th;
  int          fails = 0;
  int          total_checks = 0;
  // data = {ctrl, stop, start}; t is temperature after the frame
  scc_row_type rows [8] = '{
    '{24'h001005, 1'b0, 8'd0, 8'h00}, '{24'h001005, 1'b1, 8'd0, 8'h01},
    '{24'h002222, 1'b0, 8'd0, 8'h02}, '{24'h011005, 1'b0, 8'd131, 8'h06},
    '{24'h021005, 1'b0, 8'd150, 8'h00}, '{24'h031005, 1'b0, 8'd255, 8'h00},
    '{24'h001005, 1'b0, 8'd111, 8'h04}, '{24'h011005, 1'b0, 8'd130, 8'h00}};

  scc_link_if lnk ();
  always #5 pclk = ~pclk;

  // full half period so the readback path keeps up with the link
  scc_host #(.HALF_CYC(`SCC_SCLK_HALF_CYC)) scc_host_i (.pclk(pclk), .presetn(presetn),
    .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk.host_mp), .chip_disable_out(cd),
    .receiver_off_out(ro), .clock_style_out(cs));
  scc_device scc_device_i (.pclk(pclk), .presetn(presetn), .lnk(lnk.device_mp),
    .chip_disable(cd), .serial_receiver_off_request(ro), .clock_input_style_select(cs),
    .main_clock_pos(mcp), .main_clock_neg(mcn), .junction_temp(temp), .fault_flags(flags),
    .received_check_value(rcv), .computed_check_value(cmp), .start_addr(st),
    .stop_addr(sp), .thermal_limit_select(th), .main_clock_level(mcl));
  scc_link_checker #(.HALF_CYC(`SCC_SCLK_HALF_CYC)) scc_link_checker_i (.pclk(pclk),
    .presetn(presetn),
    .serial_clock_pos(lnk.serial_clock_pos), .select_pos(lnk.select_pos),
    .serial_in_line(lnk.serial_in_line), .fault_out(lnk.fault_out),
    .fault_oe(lnk.fault_oe), .chip_disable(cd), .serial_receiver_off_request(ro));

  function automatic logic [7:0] scc_ref_crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction : scc_ref_crc

  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk

  task lim(input int n, input int max);
    if (n >= max) begin
      fails++;
      $display("BAD wait exp done seen timeout");
      print_verdict();
    end
  endtask : lim

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    lim(n, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // host sends the data word msb first, so start goes in the top byte
  task frame(input logic [23:0] d, input logic c, input logic [31:0] base);
    int n;
    apb(1'b1, `SCC_OFF_DATA, {8'h00, d[7:0], d[15:8], d[23:16]});
    apb(1'b1, `SCC_OFF_CTRL, base | 32'h1 | {30'h0, c, 1'b0});
    n = 0;
    do begin
      apb(1'b0, `SCC_OFF_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    lim(n, 200);
    repeat (8) @(posedge pclk);
  endtask : frame

  // chip disable pulse; temperature parked low so it cannot re-set
  task clear_flags;
    temp <= 8'h00;
    apb(1'b1, `SCC_OFF_CTRL, 32'h4);
    apb(1'b1, `SCC_OFF_CTRL, 32'h0);
  endtask : clear_flags

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("flags", flags, 32'h0);
    chk("chip_off", cd, 32'h1);
    chk("rx_off", ro, 32'h1);
    chk("stop", sp, 32'h7f);
    chk("fault", lnk.fault_line, 32'h1);
    apb(1'b0, `SCC_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0c);
    apb(1'b0, 12'hff0, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      clear_flags();
      frame(rows[i].d, rows[i].c, 32'h0);
      temp <= rows[i].t;
      repeat (8) @(posedge pclk);
      c8 = scc_ref_crc({rows[i].d[7:0], rows[i].d[15:8], rows[i].d[23:16]});
      chk("computed", cmp, c8);
      chk("received", rcv, c8 ^ {7'h0, rows[i].c});
      chk("flags", flags, rows[i].f);
      chk("fault", lnk.fault_line, rows[i].f == 8'h00);
      apb(1'b0, `SCC_OFF_STATUS, 32'h0);
      chk("status", rd, {30'h0, rows[i].f != 8'h00, 1'b0});
      if (!rows[i].c)
        chk("ctrl", {st, sp, th}, {rows[i].d[6:0], rows[i].d[14:8], rows[i].d[17:16]});
      $display("row %0d test done", i);
    end
    clear_flags();
    frame(24'h001005, 1'b1, 32'h0);
    frame(24'h001005, 1'b0, 32'h0);
    chk("sticky", flags, 32'h01);
    apb(1'b0, `SCC_OFF_READBACK, 32'h0);
    c8 = scc_ref_crc(24'h051000);
    chk("readback", rd, {8'h00, 8'h01, c8, c8 ^ 8'h01});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("power_on", flags, 32'h0);
    $display("sticky test done");
    for (int b = 4; b <= 8; b += 4) begin
      clear_flags();
      apb(1'b1, `SCC_OFF_CTRL, b);
      frame(24'h001005, 1'b1, b);
      chk("refused", flags, 32'h0);
    end
    $display("refusal test done");
    apb(1'b1, `SCC_OFF_CTRL, 32'h0);
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, `SCC_OFF_CTRL, {27'h0, k[2], 4'h0});
      mcp <= k[1];
      mcn <= k[0];
      repeat (6) @(posedge pclk);
      chk("main_clock", mcl, k[2] ? k[1] : (k[1] & ~k[0]));
    end
    $display("clock style test done");
    print_verdict();
  end
endmodule : scc_tb_top
